// file: hdl/bsidc_addsub.v
// 8-bit adder/subtractor with carry, half-carry and overflow outputs
// assumes a purely combinational use inside the datapath slice
`timescale 1ns/1ps
`default_nettype none
module bsidc_addsub (
	input wire [7:0] i_a,
	input wire [7:0] i_b,
	input wire i_cin,
	input wire i_sub,
	output wire [7:0] o_sum,
	output wire o_carry,
	output wire o_half,
	output wire o_ovf
);
	// ----------------------------------------
	// subtract as a + ~b + ~borrow
	// ----------------------------------------
	wire [7:0] b_eff;
	wire c0;
	wire [4:0] lo;
	wire [8:0] full;
	assign b_eff = i_sub ? ~i_b : i_b;
	assign c0 = i_sub ? ~i_cin : i_cin;
	assign lo = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c0};
	assign full = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, c0};
	assign o_sum = full[7:0];
	assign o_carry = i_sub ? ~full[8] : full[8];
	assign o_half = i_sub ? ~lo[4] : lo[4];
	assign o_ovf = (i_a[7] == b_eff[7]) && (full[7] != i_a[7]);
endmodule
`default_nettype wire

// file: hdl/bsidc_core.v
// borrow-subtract, increment, decrement and clear datapath slice
// assumes one operation per cycle with memory data valid in that cycle
// Notes on behaviour
// - memory minus working register minus borrow, back to memory, four flags
// - working register minus borrow, back to working register, four flags
// - memory minus borrow, back to memory, four flags
// - memory plus one, back to memory, zero carry half overflow
// - memory minus one, back to memory, zero borrow half overflow
// - clear writes zero to the addressed memory byte
`timescale 1ns/1ps
`default_nettype none
`include "bsidc_defs.vh"
module bsidc_core (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_op_valid,
	input wire [2:0] i_op,
	input wire [7:0] i_mem_rdata,
	input wire [7:0] i_wreg_load,
	input wire i_wreg_load_en,
	output reg [7:0] o_mem_wdata,
	output wire o_mem_we,
	output wire [7:0] o_working_register,
	output wire o_zero_flag,
	output wire o_carry_flag,
	output wire o_half_borrow_flag,
	output wire o_signed_range_flag
);
	// ----------------------------------------
	// state registers
	// ----------------------------------------
	reg [7:0] wreg_r;
	reg [7:0] wreg_nxt;
	reg zf_r;
	reg zf_nxt;
	reg cf_r;
	reg cf_nxt;
	reg hf_r;
	reg hf_nxt;
	reg of_r;
	reg of_nxt;
	reg we_r;
	reg we_nxt;
	reg [7:0] wdata_nxt;
	// ----------------------------------------
	// datapath nets
	// ----------------------------------------
	reg [7:0] opa;
	reg [7:0] opb;
	reg cin;
	reg sub;
	wire [7:0] sum;
	wire co;
	wire ho;
	wire vo;
	wire sum_zero;
	// ----------------------------------------
	// decoded strobes
	// ----------------------------------------
	wire fire;
	reg dst_mem;
	reg dst_wreg;
	reg upd_flags;
	reg do_clear;
	assign fire = i_ce & i_op_valid;
	// ----------------------------------------
	// operation decode
	// ----------------------------------------
	always @* begin
		dst_mem = 1'b0;
		dst_wreg = 1'b0;
		upd_flags = 1'b0;
		do_clear = 1'b0;
		case (i_op)
			`BSIDC_OP_SUBC_MA: begin
				dst_mem = 1'b1;
				upd_flags = 1'b1;
			end
			`BSIDC_OP_SUBC_A: begin
				dst_wreg = 1'b1;
				upd_flags = 1'b1;
			end
			`BSIDC_OP_SUBC_M: begin
				dst_mem = 1'b1;
				upd_flags = 1'b1;
			end
			`BSIDC_OP_INC_M: begin
				dst_mem = 1'b1;
				upd_flags = 1'b1;
			end
			`BSIDC_OP_DEC_M: begin
				dst_mem = 1'b1;
				upd_flags = 1'b1;
			end
			`BSIDC_OP_CLR_M: begin
				dst_mem = 1'b1;
				do_clear = 1'b1;
			end
			default: begin
				dst_mem = 1'b0;
			end
		endcase
	end
	// ----------------------------------------
	// operand select
	// ----------------------------------------
	always @* begin
		opa = i_mem_rdata;
		opb = `BSIDC_ZERO;
		cin = cf_r;
		sub = 1'b1;
		case (i_op)
			`BSIDC_OP_SUBC_MA: begin
				opb = wreg_r;
			end
			`BSIDC_OP_SUBC_A: begin
				opa = wreg_r;
			end
			`BSIDC_OP_SUBC_M: begin
				opb = `BSIDC_ZERO;
			end
			`BSIDC_OP_INC_M: begin
				opb = `BSIDC_ONE;
				cin = 1'b0;
				sub = 1'b0;
			end
			`BSIDC_OP_DEC_M: begin
				opb = `BSIDC_ONE;
				cin = 1'b0;
			end
			default: begin
				opb = `BSIDC_ZERO;
			end
		endcase
	end
	bsidc_addsub u_alu (
		.i_a(opa),
		.i_b(opb),
		.i_cin(cin),
		.i_sub(sub),
		.o_sum(sum),
		.o_carry(co),
		.o_half(ho),
		.o_ovf(vo)
	);
	assign sum_zero = (sum == `BSIDC_ZERO);
	// ----------------------------------------
	// working register next value
	// ----------------------------------------
	always @* begin
		wreg_nxt = wreg_r;
		if (i_wreg_load_en) begin
			wreg_nxt = i_wreg_load;
		end
		if (fire && dst_wreg) begin
			wreg_nxt = sum;
		end
	end
	// ----------------------------------------
	// status flags next value
	// ----------------------------------------
	always @* begin
		zf_nxt = zf_r;
		cf_nxt = cf_r;
		hf_nxt = hf_r;
		of_nxt = of_r;
		if (fire && upd_flags) begin
			zf_nxt = sum_zero;
			cf_nxt = co;
			hf_nxt = ho;
			of_nxt = vo;
		end
	end
	// ----------------------------------------
	// memory write port next value
	// ----------------------------------------
	always @* begin
		we_nxt = fire & dst_mem;
		wdata_nxt = o_mem_wdata;
		if (fire && dst_mem) begin
			wdata_nxt = do_clear ? `BSIDC_ZERO : sum;
		end
	end
	// ----------------------------------------
	// working register flip-flops
	// ----------------------------------------
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wreg_r <= `BSIDC_RST_BYTE;
		end else if (i_ce) begin
			wreg_r <= wreg_nxt;
		end
	end
	// ----------------------------------------
	// flag flip-flops
	// ----------------------------------------
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			zf_r <= 1'b0;
			cf_r <= 1'b0;
			hf_r <= 1'b0;
			of_r <= 1'b0;
		end else if (i_ce) begin
			zf_r <= zf_nxt;
			cf_r <= cf_nxt;
			hf_r <= hf_nxt;
			of_r <= of_nxt;
		end
	end
	// ----------------------------------------
	// write port flip-flops
	// ----------------------------------------
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			we_r <= 1'b0;
			o_mem_wdata <= `BSIDC_RST_BYTE;
		end else if (i_ce) begin
			we_r <= we_nxt;
			o_mem_wdata <= wdata_nxt;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_mem_we = we_r & i_ce;
	assign o_working_register = wreg_r;
	assign o_zero_flag = zf_r;
	assign o_carry_flag = cf_r;
	assign o_half_borrow_flag = hf_r;
	assign o_signed_range_flag = of_r;
endmodule
`default_nettype wire

// file: hdl/bsidc_defs.vh
// constants for the borrow-subtract / inc / dec / clear datapath slice
// assumes inclusion by bare name from the design files
`ifndef BSIDC_DEFS_VH
`define BSIDC_DEFS_VH
// operation codes from the decoder
`define BSIDC_OP_NONE 3'h0
`define BSIDC_OP_SUBC_MA 3'h1
`define BSIDC_OP_SUBC_A 3'h2
`define BSIDC_OP_SUBC_M 3'h3
`define BSIDC_OP_INC_M 3'h4
`define BSIDC_OP_DEC_M 3'h5
`define BSIDC_OP_CLR_M 3'h6
// widths, reset value and byte constants
`define BSIDC_W 8
`define BSIDC_OP_W 3
`define BSIDC_RST_BYTE 8'h00
`define BSIDC_ONE 8'h01
`define BSIDC_ZERO 8'h00
`endif

// file: verif/bsidc_core_props.sv
// slice port checker, bound into bsidc_core
`timescale 1ns/1ps
`default_nettype none
module bsidc_core_props (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_op_valid,
	input wire logic [2:0] i_op,
	input wire logic [7:0] i_mem_rdata,
	input wire logic [7:0] o_mem_wdata,
	input wire logic o_mem_we,
	input wire logic [7:0] o_working_register,
	input wire logic o_zero_flag,
	input wire logic o_carry_flag,
	input wire logic o_half_borrow_flag,
	input wire logic o_signed_range_flag
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	wire go = i_ce & i_op_valid;
	wire [8:0] mw = {o_carry_flag, o_mem_wdata};
	property p_ma;
		go && i_op == 3'h1 |=> mw == {1'b0, $past(i_mem_rdata)} - $past(o_working_register)
			- $past(o_carry_flag);
	endproperty
	a_ma: assert property (p_ma) else $error("sub mem bad");
	property p_a;
		go && i_op == 3'h2 |=> {o_carry_flag, o_working_register}
			== {1'b0, $past(o_working_register)} - $past(o_carry_flag);
	endproperty
	a_a: assert property (p_a) else $error("sub wreg bad");
	property p_m;
		go && i_op == 3'h3 |=> mw == {1'b0, $past(i_mem_rdata)} - $past(o_carry_flag);
	endproperty
	a_m: assert property (p_m) else $error("sub borrow bad");
	property p_inc;
		go && i_op == 3'h4 |=> mw == {1'b0, $past(i_mem_rdata)} + 9'h001
			&& o_zero_flag == ($past(i_mem_rdata) == 8'hff)
			&& o_half_borrow_flag == ($past(i_mem_rdata[3:0]) == 4'hf)
			&& o_signed_range_flag == ($past(i_mem_rdata) == 8'h7f);
	endproperty
	a_inc: assert property (p_inc) else $error("inc bad");
	property p_dec;
		go && i_op == 3'h5 |=> mw == {1'b0, $past(i_mem_rdata)} - 9'h001;
	endproperty
	a_dec: assert property (p_dec) else $error("dec bad");
	property p_clr;
		go && i_op == 3'h6 |=> o_mem_wdata == 8'h00 && $stable(o_carry_flag)
			&& $stable(o_zero_flag);
	endproperty
	a_clr: assert property (p_clr) else $error("clear bad");
	property p_fl;
		go && i_op == 3'h5 |=> o_zero_flag == ($past(i_mem_rdata) == 8'h01)
			&& o_half_borrow_flag == ($past(i_mem_rdata[3:0]) == 4'h0)
			&& o_signed_range_flag == ($past(i_mem_rdata) == 8'h80);
	endproperty
	a_fl: assert property (p_fl) else $error("flags bad");
	property p_we;
		go && i_op != 3'h0 && i_op != 3'h2 && i_op != 3'h7 ##1 i_ce |-> o_mem_we;
	endproperty
	a_we: assert property (p_we) else $error("write strobe missing");
	property p_we_idle;
		!go && i_ce |=> !o_mem_we;
	endproperty
	a_we_idle: assert property (p_we_idle) else $error("write strobe stray");
endmodule
bind bsidc_core bsidc_core_props u_props (.i_sys_clk, .i_rst, .i_ce, .i_op_valid, .i_op,
	.i_mem_rdata, .o_mem_wdata, .o_mem_we, .o_working_register, .o_zero_flag, .o_carry_flag,
	.o_half_borrow_flag, .o_signed_range_flag);
`default_nettype wire

// file: verif/bsidc_mem_model.sv
// data memory model; write lands on the edge after the strobe
`timescale 1ns/1ps
`default_nettype none
module bsidc_mem_model (
	input wire logic i_sys_clk,
	input wire logic [1:0] i_addr,
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem_r [0:3];
	logic [1:0] wa_r;
	assign o_rdata = mem_r[i_addr];
	always @(posedge i_sys_clk) begin
		if (i_we)
			mem_r[wa_r] <= i_wdata;
		wa_r <= i_addr;
	end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for bsidc_core with memory model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst = 1'b1, v = 1'b0, le = 1'b0, ce = 1'b1;
	logic [2:0] op = 3'h0;
	logic [1:0] a = 2'h0;
	logic [7:0] ld = 8'h20;
	wire [7:0] rd, wd, wr;
	wire we, z, cy, h, ov;
	int n_errors = 0, check_count = 0, cyc = 0;
	bsidc_core u_bsidc_core (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_op_valid(v), .i_op(op),
		.i_mem_rdata(rd), .i_wreg_load(ld), .i_wreg_load_en(le),
		.o_mem_wdata(wd), .o_mem_we(we), .o_working_register(wr), .o_zero_flag(z),
		.o_carry_flag(cy), .o_half_borrow_flag(h), .o_signed_range_flag(ov));
	bsidc_mem_model u_bsidc_mem_model (.i_sys_clk(clk), .i_addr(a), .i_we(we), .i_wdata(wd),
		.o_rdata(rd));
	initial forever #5 clk = ~clk;
	task results;
		if (n_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) if (++cyc > 200) begin
		n_errors++;
		results();
	end
	task chk(input string s, input logic [8:0] e, input logic [8:0] g);
		check_count++;
		if (g !== e) begin
			$display("Error %s exp %h got %h", s, e, g);
			n_errors++;
		end
	endtask
	task run(input logic [2:0] c, input logic [1:0] ad);
		op = c;
		a = ad;
		v = 1'b1;
		@(posedge clk) #1 v = 1'b0;
		chk("we", {8'h00, ce && c != 3'h0 && c != 3'h2 && c != 3'h7}, {8'h00, we});
		@(posedge clk) #1;
		chk("we end", 9'h000, {8'h00, we});
	endtask
	task t_subc;
		le = 1'b1;
		@(posedge clk) #1 le = 1'b0;
		run(3'h1, 2'h0);
		chk("mem0", 9'h1f0, {cy, u_bsidc_mem_model.mem_r[0]});
		run(3'h3, 2'h1);
		chk("mem1", 9'h1ff, {cy, u_bsidc_mem_model.mem_r[1]});
		run(3'h2, 2'h1);
		chk("wreg", 9'h01f, {cy, wr});
		chk("zho", 9'h002, {6'h00, z, h, ov});
	endtask
	task t_incdec;
		run(3'h4, 2'h2);
		chk("inc", 9'h100, {cy, u_bsidc_mem_model.mem_r[2]});
		chk("inc z", 9'h001, {8'h00, z});
		run(3'h6, 2'h0);
		chk("clr", 9'h100, {cy, u_bsidc_mem_model.mem_r[0]});
		run(3'h5, 2'h3);
		chk("dec", 9'h07f, {cy, u_bsidc_mem_model.mem_r[3]});
		chk("dec zho", 9'h003, {6'h00, z, h, ov});
	endtask
	task t_freeze;
		ce = 1'b0;
		run(3'h6, 2'h3);
		ce = 1'b1;
		chk("freeze mem", 9'h07f, {cy, u_bsidc_mem_model.mem_r[3]});
		chk("freeze zho", 9'h003, {6'h00, z, h, ov});
		run(3'h7, 2'h2);
		chk("idle mem", 9'h000, {cy, u_bsidc_mem_model.mem_r[2]});
		chk("idle wreg", 9'h01f, {1'b0, wr});
	endtask
	initial begin
		u_bsidc_mem_model.mem_r[0] = 8'h10;
		u_bsidc_mem_model.mem_r[1] = 8'h00;
		u_bsidc_mem_model.mem_r[2] = 8'hff;
		u_bsidc_mem_model.mem_r[3] = 8'h80;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		t_subc();
		t_incdec();
		t_freeze();
		results();
	end
endmodule
`default_nettype wire
